// ==== rtl/alsr_params.svh ====
/*
  Constants of the light sensor register block: command codes, field
  positions, reset values and timing figures in milliseconds and ns.
  Assumes it is included by bare name wherever these are needed.
*/
`ifndef ALSR_PARAMS_SVH
`define ALSR_PARAMS_SVH

// Command codes
`define ALSR_CMD_CONF 8'h00
`define ALSR_CMD_HIGH 8'h01
`define ALSR_CMD_LOW 8'h02
`define ALSR_CMD_PSM 8'h03
`define ALSR_CMD_LIGHT 8'h04
`define ALSR_CMD_WHITE 8'h05
`define ALSR_CMD_STAT 8'h06

// Field positions
`define ALSR_SD_BIT 0
`define ALSR_IRQ_ON_BIT 1
`define ALSR_IT_HI 9
`define ALSR_IT_LO 6
`define ALSR_GAIN_HI 12
`define ALSR_GAIN_LO 11
`define ALSR_PSM_SEL_HI 2
`define ALSR_PSM_SEL_LO 1
`define ALSR_PSM_ON_BIT 0
`define ALSR_STAT_BELOW_BIT 15
`define ALSR_STAT_ABOVE_BIT 14

// Reset values
`define ALSR_CONF_RST 16'h0001
`define ALSR_PSM_RST 3'h0
`define ALSR_THR_RST 16'h0000

// Integration time codes
`define ALSR_IT_CODE_25 4'hc
`define ALSR_IT_CODE_50 4'h8
`define ALSR_IT_CODE_100 4'h0
`define ALSR_IT_CODE_200 4'h1
`define ALSR_IT_CODE_400 4'h2
`define ALSR_IT_CODE_800 4'h3

// Integration times in ms (25, 50, 100, 200, 400, 800)
`define ALSR_IT_25_MS 13'h0019
`define ALSR_IT_50_MS 13'h0032
`define ALSR_IT_100_MS 13'h0064
`define ALSR_IT_200_MS 13'h00c8
`define ALSR_IT_400_MS 13'h0190
`define ALSR_IT_800_MS 13'h0320

// Idle after integration, per mode, in ms (500, 1000, 2000, 4000)
`define ALSR_IDLE_M1_MS 13'h01f4
`define ALSR_IDLE_M2_MS 13'h03e8
`define ALSR_IDLE_M3_MS 13'h07d0
`define ALSR_IDLE_M4_MS 13'h0fa0

// Clock period and one millisecond, both in ns
`define ALSR_SYS_CLK_NS 4
`define ALSR_MS_NS 1000000

`endif

// ==== rtl/alsr_pkg.sv ====
/*
  Types and decode functions of the light sensor register block.
  Assumes alsr_params.svh is on the include path.
*/
`default_nettype none
package alsr_pkg;
`include "alsr_params.svh"

  // Measurement sequencer, Gray along OFF-INTEG-IDLE-INTEG
  typedef enum logic [1:0]
  {
    ST_OFF = 2'h0,
    ST_INTEG = 2'h1,
    ST_IDLE = 2'h3
  } alsr_state_t;

  // Period length in milliseconds
  typedef logic [12:0] alsr_ms_t;

  // Integration time code to ms; unknown codes run as 100 ms
  function automatic alsr_ms_t it_ms(input logic [3:0] code);
    case (code)
      `ALSR_IT_CODE_25: it_ms = `ALSR_IT_25_MS;
      `ALSR_IT_CODE_50: it_ms = `ALSR_IT_50_MS;
      `ALSR_IT_CODE_200: it_ms = `ALSR_IT_200_MS;
      `ALSR_IT_CODE_400: it_ms = `ALSR_IT_400_MS;
      `ALSR_IT_CODE_800: it_ms = `ALSR_IT_800_MS;
      default: it_ms = `ALSR_IT_100_MS;
    endcase
  endfunction

  // Power saving mode to idle ms after an integration
  function automatic alsr_ms_t idle_ms(input logic [1:0] mode);
    case (mode)
      2'h0: idle_ms = `ALSR_IDLE_M1_MS;
      2'h1: idle_ms = `ALSR_IDLE_M2_MS;
      2'h2: idle_ms = `ALSR_IDLE_M3_MS;
      default: idle_ms = `ALSR_IDLE_M4_MS;
    endcase
  endfunction
endpackage
`default_nettype wire

// ==== rtl/alsr_req_if.sv ====
/*
  Command carrier between the crossing logic and the register core,
  all on sys_clk. Assumes the request fields hold steady while
  req_valid is seen and until the response returns.
*/
`timescale 1ns/1ps
`default_nettype none
interface alsr_req_if;
  logic req_valid; // One-cycle command pulse
  logic req_write; // High for a write
  logic [7:0] req_code; // Command code
  logic [15:0] req_wdata; // Write data
  logic rsp_valid; // One-cycle answer pulse
  logic [15:0] rsp_rdata; // Read data, zero for writes
  modport cdc (output req_valid, req_write, req_code, req_wdata,
               input rsp_valid, rsp_rdata);
  modport core (input req_valid, req_write, req_code, req_wdata,
                output rsp_valid, rsp_rdata);
endinterface
`default_nettype wire

// ==== rtl/alsr_period.sv ====
/*
  Millisecond period timer: a start pulse loads a length in ms, done
  pulses once when it has elapsed. Assumes sys_clk and a length of at
  least one ms; a new start restarts it at once.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alsr_params.svh"
module alsr_period #(
  parameter int CYC_PER_MS = `ALSR_MS_NS / `ALSR_SYS_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire alsr_pkg::alsr_ms_t len_ms,
  output logic done
);
  localparam int PW = $clog2(CYC_PER_MS + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

  logic [PW-1:0] pre_reg, pre_next; // Cycles within the current ms
  alsr_pkg::alsr_ms_t left_reg, left_next; // Whole ms still to run
  logic run_reg, run_next; // Timer counting
  logic done_reg, done_next; // Elapsed pulse

  // Start wins over counting, so a restart never sees a stale done
  always_comb
  begin
    pre_next = pre_reg;
    left_next = left_reg;
    run_next = run_reg;
    done_next = 1'b0;
    if (start)
    begin
      pre_next = '0;
      left_next = len_ms;
      run_next = 1'b1;
    end
    else if (run_reg)
    begin
      if (pre_reg == PRE_LAST)
      begin
        pre_next = '0;
        left_next = left_reg - 13'h0001;
        if (left_reg == 13'h0001)
        begin
          run_next = 1'b0;
          done_next = 1'b1;
        end
      end
      else
        pre_next = pre_reg + 1'b1;
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_reg <= '0;
      left_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_next;
      left_reg <= left_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule
`default_nettype wire

// ==== rtl/alsr_cdc.sv ====
/*
  Command crossing between the serial link engine on link_clk and the
  register core on sys_clk, by a toggle handshake each way. Assumes
  the engine presents cmd_* on link_clk and holds them for one edge.
*/
`timescale 1ns/1ps
`default_nettype none
module alsr_cdc (
  input wire logic link_clk,
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  alsr_req_if.cdc bus
);
  // Link side: held command, stable until the answer toggles back
  logic ready_l_reg, ready_l_next;
  logic tgl_l_reg, tgl_l_next;
  logic write_l_reg, write_l_next;
  logic [7:0] code_l_reg, code_l_next;
  logic [15:0] wdata_l_reg, wdata_l_next;
  logic ack_sync1_l_reg, ack_sync2_l_reg; // Answer toggle synchroniser
  logic ack_seen_l_reg, ack_seen_l_next;
  logic rsp_valid_l_reg, rsp_valid_l_next;
  logic [15:0] rsp_data_l_reg, rsp_data_l_next;
  // Sys side
  logic req_sync1_s_reg, req_sync2_s_reg; // Request toggle synchroniser
  logic req_seen_s_reg;
  logic req_valid_s_reg;
  logic ack_tgl_s_reg, ack_tgl_s_next;
  logic [15:0] rsp_data_s_reg, rsp_data_s_next;

  // Link side next values; a command while busy is dropped
  always_comb
  begin
    ready_l_next = ready_l_reg;
    tgl_l_next = tgl_l_reg;
    write_l_next = write_l_reg;
    code_l_next = code_l_reg;
    wdata_l_next = wdata_l_reg;
    ack_seen_l_next = ack_seen_l_reg;
    rsp_valid_l_next = 1'b0;
    rsp_data_l_next = rsp_data_l_reg;
    if (ready_l_reg && cmd_valid)
    begin
      ready_l_next = 1'b0;
      tgl_l_next = ~tgl_l_reg;
      write_l_next = cmd_write;
      code_l_next = cmd_code;
      wdata_l_next = cmd_wdata;
    end
    // Answer word is steady: sys side wrote it in the same cycle as the toggle
    if (ack_sync2_l_reg != ack_seen_l_reg)
    begin
      ack_seen_l_next = ack_sync2_l_reg;
      rsp_valid_l_next = 1'b1;
      rsp_data_l_next = rsp_data_s_reg;
      ready_l_next = 1'b1;
    end
  end

  // Link side registers
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_l_reg <= 1'b1;
      tgl_l_reg <= 1'b0;
      write_l_reg <= 1'b0;
      code_l_reg <= 8'h00;
      wdata_l_reg <= 16'h0000;
      ack_sync1_l_reg <= 1'b0;
      ack_sync2_l_reg <= 1'b0;
      ack_seen_l_reg <= 1'b0;
      rsp_valid_l_reg <= 1'b0;
      rsp_data_l_reg <= 16'h0000;
    end
    else
    begin
      ready_l_reg <= ready_l_next;
      tgl_l_reg <= tgl_l_next;
      write_l_reg <= write_l_next;
      code_l_reg <= code_l_next;
      wdata_l_reg <= wdata_l_next;
      ack_sync1_l_reg <= ack_tgl_s_reg;
      ack_sync2_l_reg <= ack_sync1_l_reg;
      ack_seen_l_reg <= ack_seen_l_next;
      rsp_valid_l_reg <= rsp_valid_l_next;
      rsp_data_l_reg <= rsp_data_l_next;
    end
  end

  // Sys side: latch the answer and toggle it home in the same cycle
  always_comb
  begin
    ack_tgl_s_next = ack_tgl_s_reg;
    rsp_data_s_next = rsp_data_s_reg;
    if (bus.rsp_valid)
    begin
      ack_tgl_s_next = ~ack_tgl_s_reg;
      rsp_data_s_next = bus.rsp_rdata;
    end
  end

  // Sys side registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_sync1_s_reg <= 1'b0;
      req_sync2_s_reg <= 1'b0;
      req_seen_s_reg <= 1'b0;
      req_valid_s_reg <= 1'b0;
      ack_tgl_s_reg <= 1'b0;
      rsp_data_s_reg <= 16'h0000;
    end
    else
    begin
      req_sync1_s_reg <= tgl_l_reg;
      req_sync2_s_reg <= req_sync1_s_reg;
      req_seen_s_reg <= req_sync2_s_reg;
      req_valid_s_reg <= req_sync2_s_reg != req_seen_s_reg;
      ack_tgl_s_reg <= ack_tgl_s_next;
      rsp_data_s_reg <= rsp_data_s_next;
    end
  end

  // Held link fields are steady for the whole handshake
  assign bus.req_valid = req_valid_s_reg;
  assign bus.req_write = write_l_reg;
  assign bus.req_code = code_l_reg;
  assign bus.req_wdata = wdata_l_reg;
  assign cmd_ready = ready_l_reg;
  assign rsp_valid = rsp_valid_l_reg;
  assign rsp_rdata = rsp_data_l_reg;
endmodule
`default_nettype wire

// ==== rtl/alsr_top.sv ====
/*
  Register side of the ambient light sensor: command registers behind
  the serial link, result and status registers, and the measurement
  sequencer with power saving refresh. Assumes the link engine on
  link_clk and a front end that integrates while integ_on is high and
  presents its counts on light_in and white_in, on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alsr_params.svh"
module alsr_top #(
  parameter int CYC_PER_MS = `ALSR_MS_NS / `ALSR_SYS_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  input wire logic [15:0] light_in,
  input wire logic [15:0] white_in,
  output logic integ_on,
  output logic [1:0] gain_sel
);
  alsr_req_if bus (); // Sys-side command carrier

  // Configuration
  logic shut_reg, shut_next; // sensor_shutdown
  logic irq_on_reg, irq_on_next; // window_irq_on
  logic [3:0] it_sel_reg, it_sel_next; // integration_time_sel
  logic [1:0] gain_reg, gain_next; // gain_sel
  logic [15:0] high_reg, high_next; // Upper window bound
  logic [15:0] low_reg, low_next; // Lower window bound
  logic [1:0] psm_sel_reg, psm_sel_next; // power_saving_select
  logic psm_on_reg, psm_on_next; // power_saving_on
  // Results and status
  logic [15:0] light_reg, light_next; // light_count
  logic [15:0] white_reg, white_next; // White channel count
  logic below_reg, below_next; // below_window_flag
  logic above_reg, above_next; // above_window_flag
  // Sequencer
  alsr_pkg::alsr_state_t state_reg, state_next;
  logic integ_reg, integ_next; // Front end integrating
  logic tmr_start; // Load the period timer
  alsr_pkg::alsr_ms_t tmr_len; // Length to load
  logic tmr_done; // Period elapsed
  // Answer
  logic rsp_valid_reg, rsp_valid_next;
  logic [15:0] rsp_rdata_reg, rsp_rdata_next;

  // Link crossing
  alsr_cdc u_cdc (
    .link_clk (link_clk),
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .cmd_valid (cmd_valid),
    .cmd_write (cmd_write),
    .cmd_code (cmd_code),
    .cmd_wdata (cmd_wdata),
    .cmd_ready (cmd_ready),
    .rsp_valid (rsp_valid),
    .rsp_rdata (rsp_rdata),
    .bus (bus)
  );

  // Integration and idle timing
  alsr_period #(.CYC_PER_MS(CYC_PER_MS)) u_period (
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .start (tmr_start),
    .len_ms (tmr_len),
    .done (tmr_done)
  );

  // Register access, then sequencer; sequencer flag sets come last
  // so an event in the same cycle as a status read is never lost
  always_comb
  begin
    shut_next = shut_reg;
    irq_on_next = irq_on_reg;
    it_sel_next = it_sel_reg;
    gain_next = gain_reg;
    high_next = high_reg;
    low_next = low_reg;
    psm_sel_next = psm_sel_reg;
    psm_on_next = psm_on_reg;
    light_next = light_reg;
    white_next = white_reg;
    below_next = below_reg;
    above_next = above_reg;
    state_next = state_reg;
    integ_next = integ_reg;
    tmr_start = 1'b0;
    tmr_len = alsr_pkg::it_ms(it_sel_reg);
    rsp_valid_next = 1'b0;
    rsp_rdata_next = rsp_rdata_reg;
    if (bus.req_valid)
    begin
      rsp_valid_next = 1'b1;
      rsp_rdata_next = 16'h0000;
      if (bus.req_write)
      begin
        case (bus.req_code)
          `ALSR_CMD_CONF:
          begin
            shut_next = bus.req_wdata[`ALSR_SD_BIT];
            irq_on_next = bus.req_wdata[`ALSR_IRQ_ON_BIT];
            it_sel_next = bus.req_wdata[`ALSR_IT_HI:`ALSR_IT_LO];
            gain_next = bus.req_wdata[`ALSR_GAIN_HI:`ALSR_GAIN_LO];
          end
          `ALSR_CMD_HIGH: high_next = bus.req_wdata;
          `ALSR_CMD_LOW: low_next = bus.req_wdata;
          // Bits 15:3 not stored; host keeps them zero
          `ALSR_CMD_PSM:
          begin
            psm_sel_next =
              bus.req_wdata[`ALSR_PSM_SEL_HI:`ALSR_PSM_SEL_LO];
            psm_on_next = bus.req_wdata[`ALSR_PSM_ON_BIT];
          end
          // Result and status registers ignore writes
          default: ;
        endcase
      end
      else
      begin
        case (bus.req_code)
          `ALSR_CMD_LIGHT: rsp_rdata_next = light_reg;
          `ALSR_CMD_WHITE: rsp_rdata_next = white_reg;
          `ALSR_CMD_STAT:
          begin
            rsp_rdata_next[`ALSR_STAT_BELOW_BIT] = below_reg;
            rsp_rdata_next[`ALSR_STAT_ABOVE_BIT] = above_reg;
            below_next = 1'b0;
            above_next = 1'b0;
          end
          // Write-only and unmapped codes read as zero
          default: ;
        endcase
      end
    end
    case (state_reg)
      // Shut down: last result stays readable
      alsr_pkg::ST_OFF:
      begin
        integ_next = 1'b0;
        if (!shut_reg)
        begin
          tmr_start = 1'b1;
          state_next = alsr_pkg::ST_INTEG;
          integ_next = 1'b1;
        end
      end
      alsr_pkg::ST_INTEG:
      begin
        if (shut_reg)
        begin
          state_next = alsr_pkg::ST_OFF;
          integ_next = 1'b0;
        end
        else if (tmr_done)
        begin
          light_next = light_in;
          white_next = white_in;
          if (irq_on_reg && light_in < low_reg)
            below_next = 1'b1;
          if (irq_on_reg && light_in > high_reg)
            above_next = 1'b1;
          tmr_start = 1'b1;
          if (psm_on_reg)
          begin
            // Idle out the rest of the refresh period
            tmr_len = alsr_pkg::idle_ms(psm_sel_reg);
            state_next = alsr_pkg::ST_IDLE;
            integ_next = 1'b0;
          end
        end
      end
      alsr_pkg::ST_IDLE:
      begin
        if (shut_reg)
          state_next = alsr_pkg::ST_OFF;
        else if (tmr_done)
        begin
          tmr_start = 1'b1;
          state_next = alsr_pkg::ST_INTEG;
          integ_next = 1'b1;
        end
      end
      default:
      begin
        state_next = alsr_pkg::ST_OFF;
        integ_next = 1'b0;
      end
    endcase
  end

  // State registers; comes up shut down, as after power-on
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shut_reg <= 1'(`ALSR_CONF_RST >> `ALSR_SD_BIT);
      irq_on_reg <= 1'b0;
      it_sel_reg <= `ALSR_IT_CODE_100;
      gain_reg <= 2'h0;
      high_reg <= `ALSR_THR_RST;
      low_reg <= `ALSR_THR_RST;
      psm_sel_reg <= 2'(`ALSR_PSM_RST >> `ALSR_PSM_SEL_LO);
      psm_on_reg <= 1'b0;
      light_reg <= 16'h0000;
      white_reg <= 16'h0000;
      below_reg <= 1'b0;
      above_reg <= 1'b0;
      state_reg <= alsr_pkg::ST_OFF;
      integ_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= 16'h0000;
    end
    else
    begin
      shut_reg <= shut_next;
      irq_on_reg <= irq_on_next;
      it_sel_reg <= it_sel_next;
      gain_reg <= gain_next;
      high_reg <= high_next;
      low_reg <= low_next;
      psm_sel_reg <= psm_sel_next;
      psm_on_reg <= psm_on_next;
      light_reg <= light_next;
      white_reg <= white_next;
      below_reg <= below_next;
      above_reg <= above_next;
      state_reg <= state_next;
      integ_reg <= integ_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_rdata_reg <= rsp_rdata_next;
    end
  end

  assign bus.rsp_valid = rsp_valid_reg;
  assign bus.rsp_rdata = rsp_rdata_reg;
  assign integ_on = integ_reg;
  assign gain_sel = gain_reg;

  // Checks, all on the system clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_psm_sel;
    bus.req_valid && bus.req_write && bus.req_code == `ALSR_CMD_PSM
      |=> psm_sel_reg == $past(bus.req_wdata[2:1]);
  endproperty
  a_psm_sel: assert property (p_psm_sel)
    else $error("mode select not taken from bits 2:1");

  property p_psm_on;
    bus.req_valid && bus.req_write && bus.req_code == `ALSR_CMD_PSM
      |=> psm_on_reg == $past(bus.req_wdata[0]);
  endproperty
  a_psm_on: assert property (p_psm_on)
    else $error("power saving enable not taken from bit 0");

  property p_read_light;
    bus.req_valid && !bus.req_write && bus.req_code == `ALSR_CMD_LIGHT
      |=> bus.rsp_valid && bus.rsp_rdata == $past(light_reg);
  endproperty
  a_read_light: assert property (p_read_light)
    else $error("light read returned wrong word");

  property p_read_white;
    bus.req_valid && !bus.req_write && bus.req_code == `ALSR_CMD_WHITE
      |=> bus.rsp_valid && bus.rsp_rdata == $past(white_reg);
  endproperty
  a_read_white: assert property (p_read_white)
    else $error("white read returned wrong word");

  property p_below;
    state_reg == alsr_pkg::ST_INTEG && tmr_done && !shut_reg
      && irq_on_reg && light_in < low_reg |=> below_reg;
  endproperty
  a_below: assert property (p_below)
    else $error("low crossing did not set flag");

  property p_above;
    state_reg == alsr_pkg::ST_INTEG && tmr_done && !shut_reg
      && irq_on_reg && light_in > high_reg |=> above_reg;
  endproperty
  a_above: assert property (p_above)
    else $error("high crossing did not set flag");

  property p_status;
    bus.req_valid && !bus.req_write && bus.req_code == `ALSR_CMD_STAT
      |=> bus.rsp_rdata[13:0] == 14'h0000
      && bus.rsp_rdata[15:14] == {$past(below_reg), $past(above_reg)};
  endproperty
  a_status: assert property (p_status)
    else $error("status word wrong");

  property p_refresh;
    state_reg == alsr_pkg::ST_INTEG && tmr_done && !shut_reg && psm_on_reg
      |-> tmr_start && tmr_len == alsr_pkg::idle_ms(psm_sel_reg)
      ##1 state_reg == alsr_pkg::ST_IDLE;
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("idle period not loaded for mode");

  property p_it_len;
    tmr_start && state_next == alsr_pkg::ST_INTEG
      |-> tmr_len == alsr_pkg::it_ms(it_sel_reg);
  endproperty
  a_it_len: assert property (p_it_len)
    else $error("integration length wrong");

  property p_irq_gate;
    $rose(below_reg) || $rose(above_reg) |-> $past(irq_on_reg);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("flag raised with window interrupt off");

  property p_hold;
    state_reg == alsr_pkg::ST_OFF |=> $stable(light_reg) && $stable(white_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result changed while shut down");

  property p_idle_quiet;
    state_reg == alsr_pkg::ST_IDLE |-> !integ_reg && !tmr_start[*1]
      or (tmr_done && !shut_reg);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("integration during idle period");

  c_idle: cover property (state_reg == alsr_pkg::ST_IDLE);
  c_wake: cover property (state_reg == alsr_pkg::ST_OFF
    ##1 state_reg == alsr_pkg::ST_INTEG);
  c_flag: cover property ($rose(below_reg) || $rose(above_reg));
  c_stat: cover property (bus.req_valid && bus.req_code == `ALSR_CMD_STAT);
endmodule
`default_nettype wire

// ==== testbench/alsr_host_model.sv ====
/*
  Link engine model: one command at a time on link_clk.
  Assumes the cmd_ready / rsp_valid handshake of the register side.
*/
`timescale 1ns/1ps
`default_nettype none
module alsr_host_model (
  input wire logic link_clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  // Idle lines at time zero
  initial
  begin
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = 26'h0;
  end
  // Held until taken; an answer that never comes returns all x
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output logic [15:0] q);
    int i;
    i = 0;
    @(posedge link_clk);
    #1;
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, d};
    while (cmd_ready !== 1'b1 && i < 40)
    begin
      @(posedge link_clk);
      #1;
      i++;
    end
    @(posedge link_clk);
    #1;
    // Released lines show the inverse, never the stale value
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b0, ~w, ~c, ~d};
    i = 0;
    while (rsp_valid !== 1'b1 && i < 40)
    begin
      @(posedge link_clk);
      #1;
      i++;
    end
    q = (i < 40) ? rsp_rdata : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
  Bench of the light sensor register side: link commands, front end
  counts and integ_on timing. Assumes CYC_PER_MS shortened to 2.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Reset falls at 1 ns, so the link side resets before its first edge
  logic sys_clk = 0, link_clk = 0, rst_n = 1;
  logic cv, cw, cr, rv, io;
  logic [7:0] cc;
  logic [15:0] cd, rd, q, li = 16'h0, wi = 16'h0;
  logic [1:0] gs;
  int fail_count = 0, comparisons = 0;
  logic [31:0] rs = 32'h5a81;
  // Clocks, link phase unrelated to sys_clk
  initial forever #2 sys_clk = ~sys_clk;
  initial
  begin
    #37;
    forever #80 link_clk = ~link_clk;
  end
  alsr_top #(.CYC_PER_MS(2)) dut (.sys_clk(sys_clk),
    .link_clk(link_clk), .rst_n(rst_n), .cmd_valid(cv),
    .cmd_write(cw), .cmd_code(cc), .cmd_wdata(cd), .cmd_ready(cr),
    .rsp_valid(rv), .rsp_rdata(rd), .light_in(li), .white_in(wi),
    .integ_on(io), .gain_sel(gs));
  alsr_host_model host (.link_clk(link_clk), .cmd_ready(cr),
    .rsp_valid(rv), .rsp_rdata(rd), .cmd_valid(cv), .cmd_write(cw),
    .cmd_code(cc), .cmd_wdata(cd));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Integration length in ms per code
  function automatic int it_exp(input logic [3:0] c);
    case (c)
      4'hc: return 25;
      4'h8: return 50;
      4'h1: return 200;
      4'h2: return 400;
      4'h3: return 800;
      default: return 100;
    endcase
  endfunction
  // Counts of cycles may slip by a handoff or two
  function automatic logic [31:0] near(input int e, input int g);
    return (g >= e - 2 && g <= e + 2) ? e : g;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Cycles integ_on stays at level l, after waiting to reach it
  task automatic meas(input logic l, output int n);
    n = 0;
    while (io !== l && n < 20000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    n = 0;
    while (io === l && n < 20000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d of %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog, about twice the expected run
  initial
  begin
    #400000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    int h, l;
    logic [15:0] v;
    logic irq;
    static logic [3:0] codes [6] = '{4'hc, 4'h8, 4'h0, 4'h1, 4'h2, 4'h3};
    #1;
    rst_n = 0;
    repeat (12) @(posedge sys_clk);
    #1;
    rst_n = 1;
    chk("integ_on", 0, io);
    chk("cmd_ready", 1, cr);
    host.xfer(1, 8'h01, 16'h8000, q);
    host.xfer(1, 8'h02, 16'h4000, q);
    host.xfer(1, 8'h03, 16'h0001, q);
    chk("write_answer", 16'h0, q);
    // Each code once, zero and full-scale counts at the ends
    foreach (codes[k])
    begin
      rs = xs(rs);
      v = (k == 0) ? 16'h0 : (k == 5) ? 16'hffff : rs[15:0];
      li = v;
      wi = rs[31:16];
      irq = rs[7] | (k == 0) | (k == 5);
      host.xfer(1, 8'h00, {3'h0, rs[9:8], 1'b0, codes[k], 4'h0, irq,
        1'b0}, q);
      // First integration may be under way; time a whole later one
      meas(0, l);
      meas(1, h);
      chk("integration", it_exp(codes[k]) * 2, near(it_exp(codes[k]) * 2,
        h));
      chk("gain_sel", rs[9:8], gs);
      host.xfer(0, 8'h04, 16'h0, q);
      chk("light_result", v, q);
      host.xfer(0, 8'h05, 16'h0, q);
      chk("white_result", wi, q);
      host.xfer(0, 8'h06, 16'h0, q);
      chk("status", {irq && v < 16'h4000, irq && v > 16'h8000, 14'h0},
        q);
      host.xfer(0, 8'h06, 16'h0, q);
      chk("status_cleared", 16'h0, q);
      host.xfer(1, 8'h00, 16'h0001, q);
    end
    // Shut down: result held, writes to results ignored
    li = ~v;
    host.xfer(1, 8'h04, 16'h1234, q);
    host.xfer(0, 8'h04, 16'h0, q);
    chk("held_result", v, q);
    host.xfer(0, 8'h03, 16'h0, q);
    chk("write_only", 16'h0, q);
    host.xfer(1, 8'h00, 16'h0000, q);
    // Refresh period per mode at 100 ms integration
    for (int m = 0; m < 4; m++)
    begin
      host.xfer(1, 8'h03, {13'h0, m[1:0], 1'b1}, q);
      meas(0, l);
      meas(1, h);
      meas(0, l);
      chk("refresh", (100 + 500 * (1 << m)) * 2, near((100 + 500 *
        (1 << m)) * 2, h + l));
    end
    complete_run();
  end
endmodule
`default_nettype wire
